/* core/skl_decoder.sv */
// skip and timer load instruction executor with apb register access
`timescale 1ns/100ps

// Summary of operation
// - serial flag test skips, clears; enabled means nop
// - timer 1 flag test skips, clears; enabled nop
// - timer 2 flag test skips, clears; enabled nop
// - timer 3 flag test skips, clears; enabled nop
// - timer 4 test gated by second control bit3
// - timer 5 test gated by second control bit1
// - detector op sets flag when pin high
// - memory bit test skips when selected bit zero
// - timer 1 load writes counter and reload
// - timer 2 load writes counter and reload
// - timer 3 load writes counter and reload
// - timer 4 load writes counter, first reload
// - second timer 4 reload written from registers
module skl_decoder #(
    parameter int ADDR_W = 8
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // instruction stream from the sequencer
    input wire logic instr_valid,
    input wire logic [9:0] instr_code,
    input wire logic [3:0] acc_val,
    input wire logic [3:0] breg_val,
    input wire logic [3:0] mem_word,
    // request events from serial and timers, and the detector enable pin
    input wire logic serial_done,
    input wire logic [4:0] tmr_event,
    input wire logic detector_enable_pin,
    // results
    output logic skip_q,
    output logic serial_start_q,
    output logic [3:0] tmr_load_q,
    output logic [7:0] tmr_load_val_q,
    output logic vd_flag_q,
    output logic [5:0] request_flag_q
);
    logic [3:0] first_ictl_q;
    logic [3:0] second_ictl_q;
    logic [7:0] tmr1_reload_reg_q;
    logic [7:0] tmr2_reload_reg_q;
    logic [7:0] tmr3_reload_reg_q;
    logic [7:0] tmr4_first_reload_reg_q;
    logic [7:0] tmr4_second_reload_reg_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic skip_d;
    logic serial_start_d;
    logic [3:0] tmr_load_d;
    logic vd_flag_d;

    // decoded operations, masked by a pending skip
    wire exec_valid = instr_valid & ~skip_q;
    wire [5:0] flag_skip_op;
    wire serial_start_op;
    wire voltage_detector_enable_op;
    wire memory_bit_zero_skip_op;
    wire [3:0] tmr_load_op;
    wire tmr4_second_load_op;

    skl_op_decode u_dec (
        .code(instr_code),
        .valid(exec_valid),
        .flag_skip_op(flag_skip_op),
        .serial_start_op(serial_start_op),
        .voltage_detector_enable_op(voltage_detector_enable_op),
        .memory_bit_zero_skip_op(memory_bit_zero_skip_op),
        .tmr_load_op(tmr_load_op),
        .tmr4_second_load_op(tmr4_second_load_op)
    );

    // enable bit feeding each flag test
    wire serial_timer4_irq_enable_bit = second_ictl_q[skl_pkg::SECOND_SERIAL_TMR4_EN_BIT];
    wire tmr1_irq_enable_bit = first_ictl_q[skl_pkg::FIRST_TMR1_EN_BIT];
    wire tmr2_irq_enable_bit = first_ictl_q[skl_pkg::FIRST_TMR2_EN_BIT];
    wire tmr3_irq_enable_bit = second_ictl_q[skl_pkg::SECOND_TMR3_EN_BIT];
    wire tmr5_irq_enable_bit = second_ictl_q[skl_pkg::SECOND_TMR5_EN_BIT];
    wire [5:0] flag_enable = {tmr5_irq_enable_bit, serial_timer4_irq_enable_bit, tmr3_irq_enable_bit,
                              tmr2_irq_enable_bit, tmr1_irq_enable_bit, serial_timer4_irq_enable_bit};

    // a flag test with its enable set is a nop
    wire [5:0] flag_hit = flag_skip_op & ~flag_enable & request_flag_q;
    wire [5:0] flag_clr;
    assign flag_clr[skl_pkg::FLAG_SERIAL] = flag_hit[skl_pkg::FLAG_SERIAL] | serial_start_op;
    assign flag_clr[5:1] = flag_hit[5:1];

    skl_flag_bank #(
        .N(skl_pkg::FLAG_COUNT)
    ) u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .set({tmr_event, serial_done}),
        .clr(flag_clr),
        .flag_q(request_flag_q)
    );

    // selected memory bit is zero
    wire mem_bit_zero = ~mem_word[instr_code[1:0]];
    wire skip_cond = (|flag_hit) | (memory_bit_zero_skip_op & mem_bit_zero);

    // skip flag: set by a taken test, consumed by the next instruction
    always_comb begin
        skip_d = skip_q;
        if (instr_valid) begin
            skip_d = exec_valid & skip_cond;
        end
    end

    // one-cycle action strobes and the sticky detector flag
    assign serial_start_d = serial_start_op;
    assign tmr_load_d = tmr_load_op;
    assign vd_flag_d = vd_flag_q | (voltage_detector_enable_op & detector_enable_pin);

    wire [7:0] load_val = {breg_val, acc_val};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_q <= 1'b0;
            serial_start_q <= 1'b0;
            tmr_load_q <= 4'h0;
            tmr_load_val_q <= skl_pkg::RELOAD_RESET;
            vd_flag_q <= 1'b0;
        end else if (ce) begin
            skip_q <= skip_d;
            serial_start_q <= serial_start_d;
            tmr_load_q <= tmr_load_d;
            if (|tmr_load_op) begin
                tmr_load_val_q <= load_val;
            end
            vd_flag_q <= vd_flag_d;
        end
    end

    // apb decode
    wire apb_setup = psel & ~penable;
    wire apb_write = psel & penable & pready_q & pwrite;
    wire [7:0] addr8 = paddr[7:0];
    wire sel_first = (addr8 == skl_pkg::ADDR_FIRST_ICTL);
    wire sel_second = (addr8 == skl_pkg::ADDR_SECOND_ICTL);
    wire sel_status = (addr8 == skl_pkg::ADDR_STATUS);
    wire sel_r1 = (addr8 == skl_pkg::ADDR_TMR1_RELOAD);
    wire sel_r2 = (addr8 == skl_pkg::ADDR_TMR2_RELOAD);
    wire sel_r3 = (addr8 == skl_pkg::ADDR_TMR3_RELOAD);
    wire sel_r4l = (addr8 == skl_pkg::ADDR_TMR4_FIRST_RELOAD);
    wire sel_r4h = (addr8 == skl_pkg::ADDR_TMR4_SECOND_RELOAD);
    wire high_zero = (ADDR_W > 8) ? (paddr >> 8) == '0 : 1'b1;
    wire sel_any = high_zero & (sel_first | sel_second | sel_status | sel_r1 | sel_r2 | sel_r3 | sel_r4l | sel_r4h);

    wire [7:0] status_val = {skip_q, vd_flag_q, request_flag_q};
    wire [31:0] read_val =
        !high_zero ? 32'h0000_0000 :
        sel_first ? {28'h000_0000, first_ictl_q} :
        sel_second ? {28'h000_0000, second_ictl_q} :
        sel_status ? {24'h00_0000, status_val} :
        sel_r1 ? {24'h00_0000, tmr1_reload_reg_q} :
        sel_r2 ? {24'h00_0000, tmr2_reload_reg_q} :
        sel_r3 ? {24'h00_0000, tmr3_reload_reg_q} :
        sel_r4l ? {24'h00_0000, tmr4_first_reload_reg_q} :
        sel_r4h ? {24'h00_0000, tmr4_second_reload_reg_q} : 32'h0000_0000;

    // access phase answered at its first edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (ce) begin
            pready_q <= apb_setup;
            pslverr_q <= apb_setup & ~sel_any;
            if (apb_setup && !pwrite) begin
                prdata_q <= read_val;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // control registers written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_ictl_q <= skl_pkg::ICTL_RESET;
            second_ictl_q <= skl_pkg::ICTL_RESET;
        end else if (ce && apb_write && high_zero) begin
            if (sel_first) begin
                first_ictl_q <= pwdata[3:0];
            end
            if (sel_second) begin
                second_ictl_q <= pwdata[3:0];
            end
        end
    end

    // reload registers: instruction loads take precedence over software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr1_reload_reg_q <= skl_pkg::RELOAD_RESET;
            tmr2_reload_reg_q <= skl_pkg::RELOAD_RESET;
            tmr3_reload_reg_q <= skl_pkg::RELOAD_RESET;
            tmr4_first_reload_reg_q <= skl_pkg::RELOAD_RESET;
            tmr4_second_reload_reg_q <= skl_pkg::RELOAD_RESET;
        end else if (ce) begin
            if (tmr_load_op[0]) begin
                tmr1_reload_reg_q <= load_val;
            end else if (apb_write && high_zero && sel_r1) begin
                tmr1_reload_reg_q <= pwdata[7:0];
            end
            if (tmr_load_op[1]) begin
                tmr2_reload_reg_q <= load_val;
            end else if (apb_write && high_zero && sel_r2) begin
                tmr2_reload_reg_q <= pwdata[7:0];
            end
            if (tmr_load_op[2]) begin
                tmr3_reload_reg_q <= load_val;
            end else if (apb_write && high_zero && sel_r3) begin
                tmr3_reload_reg_q <= pwdata[7:0];
            end
            if (tmr_load_op[3]) begin
                tmr4_first_reload_reg_q <= load_val;
            end else if (apb_write && high_zero && sel_r4l) begin
                tmr4_first_reload_reg_q <= pwdata[7:0];
            end
            if (tmr4_second_load_op) begin
                tmr4_second_reload_reg_q <= load_val;
            end else if (apb_write && high_zero && sel_r4h) begin
                tmr4_second_reload_reg_q <= pwdata[7:0];
            end
        end
    end
endmodule

/* core/skl_pkg.sv */
// package: opcodes, register map, field positions and reset values of the skip and timer load decoder
package skl_pkg;
    // instruction codes, 10 bits wide
    localparam logic [9:0] OP_SERIAL_FLAG_SKIP = 10'h288;
    localparam logic [9:0] OP_TMR1_FLAG_SKIP = 10'h280;
    localparam logic [9:0] OP_TMR2_FLAG_SKIP = 10'h281;
    localparam logic [9:0] OP_TMR3_FLAG_SKIP = 10'h282;
    localparam logic [9:0] OP_TMR4_FLAG_SKIP = 10'h283;
    localparam logic [9:0] OP_TMR5_FLAG_SKIP = 10'h284;
    localparam logic [9:0] OP_SERIAL_START = 10'h29e;
    localparam logic [9:0] OP_VOLTAGE_DETECTOR_ENABLE = 10'h293;
    localparam logic [9:0] OP_MEMORY_BIT_ZERO_SKIP = 10'h020;
    localparam logic [9:0] OP_MEMORY_BIT_MASK = 10'h3fc;
    localparam logic [9:0] OP_TMR1_LOAD = 10'h230;
    localparam logic [9:0] OP_TMR2_LOAD = 10'h231;
    localparam logic [9:0] OP_TMR3_LOAD = 10'h232;
    localparam logic [9:0] OP_TMR4_LOAD = 10'h233;
    localparam logic [9:0] OP_TMR4_SECOND_LOAD = 10'h237;

    // request flag indices inside the flag bank
    localparam int FLAG_COUNT = 6;
    localparam int FLAG_SERIAL = 0;
    localparam int FLAG_TMR1 = 1;
    localparam int FLAG_TMR2 = 2;
    localparam int FLAG_TMR3 = 3;
    localparam int FLAG_TMR4 = 4;
    localparam int FLAG_TMR5 = 5;

    // interrupt enable bit positions
    localparam int FIRST_TMR1_EN_BIT = 2;
    localparam int FIRST_TMR2_EN_BIT = 3;
    localparam int SECOND_TMR3_EN_BIT = 0;
    localparam int SECOND_TMR5_EN_BIT = 1;
    localparam int SECOND_SERIAL_TMR4_EN_BIT = 3;

    // status register fields
    localparam int STAT_VD_BIT = 6;
    localparam int STAT_SKIP_BIT = 7;

    // apb byte offsets
    localparam logic [7:0] ADDR_FIRST_ICTL = 8'h00;
    localparam logic [7:0] ADDR_SECOND_ICTL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_TMR1_RELOAD = 8'h0c;
    localparam logic [7:0] ADDR_TMR2_RELOAD = 8'h10;
    localparam logic [7:0] ADDR_TMR3_RELOAD = 8'h14;
    localparam logic [7:0] ADDR_TMR4_FIRST_RELOAD = 8'h18;
    localparam logic [7:0] ADDR_TMR4_SECOND_RELOAD = 8'h1c;

    // reset values
    localparam logic [3:0] ICTL_RESET = 4'h0;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
endpackage

/* core/skl_op_decode.sv */
// combinational decoder from instruction code to one-hot operation strobes
`timescale 1ns/100ps
module skl_op_decode (
    // instruction
    input wire logic [9:0] code,
    input wire logic valid,
    // decoded strobes, flag tests indexed as in the flag bank
    output logic [5:0] flag_skip_op,
    output logic serial_start_op,
    output logic voltage_detector_enable_op,
    output logic memory_bit_zero_skip_op,
    output logic [3:0] tmr_load_op,
    output logic tmr4_second_load_op
);
    function automatic logic is_op(input logic [9:0] c, input logic [9:0] op);
        is_op = (c == op);
    endfunction

    assign flag_skip_op[skl_pkg::FLAG_SERIAL] = valid & is_op(code, skl_pkg::OP_SERIAL_FLAG_SKIP);
    assign flag_skip_op[skl_pkg::FLAG_TMR1] = valid & is_op(code, skl_pkg::OP_TMR1_FLAG_SKIP);
    assign flag_skip_op[skl_pkg::FLAG_TMR2] = valid & is_op(code, skl_pkg::OP_TMR2_FLAG_SKIP);
    assign flag_skip_op[skl_pkg::FLAG_TMR3] = valid & is_op(code, skl_pkg::OP_TMR3_FLAG_SKIP);
    assign flag_skip_op[skl_pkg::FLAG_TMR4] = valid & is_op(code, skl_pkg::OP_TMR4_FLAG_SKIP);
    assign flag_skip_op[skl_pkg::FLAG_TMR5] = valid & is_op(code, skl_pkg::OP_TMR5_FLAG_SKIP);
    assign serial_start_op = valid & is_op(code, skl_pkg::OP_SERIAL_START);
    assign voltage_detector_enable_op = valid & is_op(code, skl_pkg::OP_VOLTAGE_DETECTOR_ENABLE);
    // low two bits carry the bit number
    assign memory_bit_zero_skip_op = valid &
        is_op(code & skl_pkg::OP_MEMORY_BIT_MASK, skl_pkg::OP_MEMORY_BIT_ZERO_SKIP);
    assign tmr_load_op[0] = valid & is_op(code, skl_pkg::OP_TMR1_LOAD);
    assign tmr_load_op[1] = valid & is_op(code, skl_pkg::OP_TMR2_LOAD);
    assign tmr_load_op[2] = valid & is_op(code, skl_pkg::OP_TMR3_LOAD);
    assign tmr_load_op[3] = valid & is_op(code, skl_pkg::OP_TMR4_LOAD);
    assign tmr4_second_load_op = valid & is_op(code, skl_pkg::OP_TMR4_SECOND_LOAD);
endmodule

/* core/skl_flag_bank.sv */
// bank of sticky request flags: hardware set wins over instruction clear
`timescale 1ns/100ps
module skl_flag_bank #(
    parameter int N = 6
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // set and clear
    input wire logic [N-1:0] set,
    input wire logic [N-1:0] clr,
    // flags
    output logic [N-1:0] flag_q
);
    logic [N-1:0] flag_d;

    for (genvar i = 0; i < N; i++) begin : g_flag
        assign flag_d[i] = set[i] | (flag_q[i] & ~clr[i]);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                flag_q[i] <= 1'b0;
            end else if (ce) begin
                flag_q[i] <= flag_d[i];
            end
        end
    end
endmodule

/* test/skl_seq_model.sv */
// sequencer model: fetches one instruction with its operands per request
`timescale 1ns/100ps
module skl_seq_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request from the bench
    input wire logic req,
    input wire logic [9:0] req_code,
    input wire logic [3:0] req_acc,
    input wire logic [3:0] req_breg,
    input wire logic [3:0] req_mem,
    // instruction port
    output logic instr_valid,
    output logic [9:0] instr_code,
    output logic [3:0] acc_val,
    output logic [3:0] breg_val,
    output logic [3:0] mem_word
);
    // a skipped instruction is still fetched; suppressing it is the core's job
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_valid <= 1'b0;
            {instr_code, acc_val, breg_val, mem_word} <= 22'h0;
        end else begin
            instr_valid <= req;
            if (req) begin
                {instr_code, acc_val, breg_val, mem_word} <= {req_code, req_acc, req_breg, req_mem};
            end else begin
                // stale operands flip so nothing leans on them
                {instr_code, acc_val, breg_val, mem_word} <= ~{instr_code, acc_val, breg_val, mem_word};
            end
        end
    end
endmodule

/* test/skl_decoder_checker.sv */
// checker: timing relations of the instruction port
`timescale 1ns/100ps
module skl_decoder_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // inputs
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic [9:0] instr_code,
    input wire logic [3:0] acc_val,
    input wire logic [3:0] breg_val,
    input wire logic [3:0] mem_word,
    input wire logic serial_done,
    input wire logic [4:0] tmr_event,
    input wire logic detector_enable_pin,
    // outputs
    input wire logic skip_q,
    input wire logic serial_start_q,
    input wire logic [3:0] tmr_load_q,
    input wire logic [7:0] tmr_load_val_q,
    input wire logic vd_flag_q,
    input wire logic [5:0] request_flag_q
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire take = ce && instr_valid && !skip_q;
    wire quiet = !serial_done && tmr_event == 5'h0;
    wire tst_t = instr_code[9:3] == 7'h50 && instr_code[2:0] < 3'h5;
    wire tst = tst_t || instr_code == skl_pkg::OP_SERIAL_FLAG_SKIP;
    wire [2:0] fidx = tst_t ? instr_code[2:0] + 3'h1 : 3'h0;
    wire flag = request_flag_q[fidx];
    wire mbit = mem_word[instr_code[1:0]];
    wire mtst = (instr_code & skl_pkg::OP_MEMORY_BIT_MASK) == skl_pkg::OP_MEMORY_BIT_ZERO_SKIP;
    wire ld = instr_code[9:2] == 8'h8c;
    wire [7:0] lval = {breg_val, acc_val};
    wire [3:0] lsel = 4'h1 << instr_code[1:0];
    sequence s_flag_skip;
        take && tst && flag && quiet ##1 skip_q;
    endsequence
    property p_skip_clear;
        s_flag_skip |-> !request_flag_q[$past(fidx)];
    endproperty
    a_skip_clear: assert property (p_skip_clear) else $error("flag kept after skip");
    property p_no_flag;
        take && tst && !flag |=> !skip_q;
    endproperty
    a_no_flag: assert property (p_no_flag) else $error("skip with flag clear");
    property p_mem;
        take && mtst |=> skip_q == !$past(mbit);
    endproperty
    a_mem: assert property (p_mem) else $error("memory bit skip wrong");
    property p_load;
        take && ld |=> tmr_load_q == $past(lsel) && tmr_load_val_q == $past(lval);
    endproperty
    a_load: assert property (p_load) else $error("timer load wrong");
    property p_second;
        take && instr_code == skl_pkg::OP_TMR4_SECOND_LOAD |=> tmr_load_q == 4'h0;
    endproperty
    a_second: assert property (p_second) else $error("second reload pulsed counter");
    property p_sst;
        take && instr_code == skl_pkg::OP_SERIAL_START && quiet |=> serial_start_q && !request_flag_q[0];
    endproperty
    a_sst: assert property (p_sst) else $error("serial start wrong");
    property p_vd;
        take && instr_code == skl_pkg::OP_VOLTAGE_DETECTOR_ENABLE && detector_enable_pin |=> vd_flag_q;
    endproperty
    a_vd: assert property (p_vd) else $error("detector flag not set");
    property p_suppress;
        ce && instr_valid && skip_q |=> !skip_q && tmr_load_q == 4'h0 && !serial_start_q;
    endproperty
    a_suppress: assert property (p_suppress) else $error("skipped instruction acted");
endmodule
bind skl_decoder skl_decoder_checker u_chk (.pclk, .presetn, .ce, .instr_valid, .instr_code, .acc_val, .breg_val,
    .mem_word, .serial_done, .tmr_event, .detector_enable_pin, .skip_q, .serial_start_q, .tmr_load_q, .tmr_load_val_q,
    .vd_flag_q, .request_flag_q);

/* test/tb_skip_and_timer_load_instr.sv */
// testbench: flag skips, timer loads, serial start, detector and bit tests
`timescale 1ns/100ps
module tb_skip_and_timer_load_instr;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
    logic pready, pslverr, rerr, req = 1'b0, serial_done = 1'b0, detector_enable_pin = 1'b0;
    logic [9:0] req_code = 10'h000, instr_code;
    logic [3:0] req_acc = 4'h0, req_breg = 4'h0, req_mem = 4'h0, acc_val, breg_val, mem_word, tmr_load_q;
    logic [4:0] tmr_event = 5'h00;
    logic instr_valid, skip_q, serial_start_q, vd_flag_q;
    logic [7:0] tmr_load_val_q;
    logic [5:0] request_flag_q;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    logic [9:0] fop [6] = '{10'h288, 10'h280, 10'h281, 10'h282, 10'h283, 10'h284};
    logic [11:0] freg [6] = '{12'h004, 12'h000, 12'h000, 12'h004, 12'h004, 12'h004};
    int fbit [6] = '{3, 2, 3, 0, 3, 1};
    initial forever #50 pclk = ~pclk;
    skl_seq_model u_seq (.pclk, .presetn, .req, .req_code, .req_acc, .req_breg, .req_mem, .instr_valid,
        .instr_code, .acc_val, .breg_val, .mem_word);
    skl_decoder #(.ADDR_W(12)) u_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .instr_valid, .instr_code, .acc_val, .breg_val, .mem_word, .serial_done, .tmr_event,
        .detector_enable_pin, .skip_q, .serial_start_q, .tmr_load_q, .tmr_load_val_q, .vd_flag_q, .request_flag_q);
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only pready high or the bench timeout ends this wait
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        // the slave answers in the first access cycle
        chk("pready wait", 32'h1, 32'(n));
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic run(input logic [9:0] c, input logic [3:0] a, input logic [3:0] b, input logic [3:0] m);
        @(posedge pclk);
        req <= 1'b1;
        req_code <= c;
        req_acc <= a;
        req_breg <= b;
        req_mem <= m;
        @(posedge pclk);
        req <= 1'b0;
        @(posedge pclk);
        #1;
    endtask
    task automatic ev(input int i);
        @(posedge pclk);
        serial_done <= (i == 0);
        tmr_event <= (i == 0) ? 5'h00 : 5'(1 << (i - 1));
        @(posedge pclk);
        serial_done <= 1'b0;
        tmr_event <= 5'h00;
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 32; a += 4) begin
            apb(1'b0, 12'(a), 32'h0);
            chk("reset read", 32'h0, rdat);
            chk("mapped err", 32'h0, {31'h0, rerr});
        end
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rerr});
        for (int i = 0; i < 6; i++) begin
            ev(i);
            apb(1'b1, freg[i], 32'(1 << fbit[i]));
            apb(1'b1, freg[i] ^ 12'h004, 32'h0);
            run(fop[i], 4'h0, 4'h0, 4'h0);
            chk("nop skip", 32'h0, {31'h0, skip_q});
            chk("nop flag", 32'h1, {31'h0, request_flag_q[i]});
            apb(1'b1, freg[i], 32'(~(1 << fbit[i]) & 15));
            apb(1'b1, freg[i] ^ 12'h004, 32'h0000_000f);
            run(fop[i], 4'h0, 4'h0, 4'h0);
            chk("skip", 32'h1, {31'h0, skip_q});
            chk("flag clear", 32'h0, {31'h0, request_flag_q[i]});
            run(10'h230, 4'h5, 4'ha, 4'h0);
            chk("skipped load", 32'h0, {28'h0, tmr_load_q});
            run(fop[i], 4'h0, 4'h0, 4'h0);
            chk("no flag skip", 32'h0, {31'h0, skip_q});
        end
        for (int i = 0; i < 4; i++) begin
            run(10'h230 + 10'(i), 4'(i + 3), 4'(12 - i), 4'h0);
            chk("load strobe", 32'(1 << i), {28'h0, tmr_load_q});
            chk("load value", {24'h0, 4'(12 - i), 4'(i + 3)}, {24'h0, tmr_load_val_q});
            apb(1'b0, 12'h00c + 12'(4 * i), 32'h0);
            chk("reload", {24'h0, 4'(12 - i), 4'(i + 3)}, rdat);
        end
        run(10'h237, 4'h1, 4'he, 4'h0);
        chk("second strobe", 32'h0, {28'h0, tmr_load_q});
        apb(1'b0, 12'h01c, 32'h0);
        chk("second reload", 32'h0000_00e1, rdat);
        ev(0);
        run(10'h29e, 4'h0, 4'h0, 4'h0);
        chk("serial start", 32'h1, {31'h0, serial_start_q});
        chk("serial flag", 32'h0, {31'h0, request_flag_q[0]});
        run(10'h293, 4'h0, 4'h0, 4'h0);
        chk("vd pin low", 32'h0, {31'h0, vd_flag_q});
        @(posedge pclk);
        detector_enable_pin <= 1'b1;
        run(10'h293, 4'h0, 4'h0, 4'h0);
        chk("vd set", 32'h1, {31'h0, vd_flag_q});
        for (int j = 0; j < 4; j++) begin
            run(10'h020 + 10'(j), 4'h0, 4'h0, 4'(1 << j));
            chk("bit one", 32'h0, {31'h0, skip_q});
            run(10'h020 + 10'(j), 4'h0, 4'h0, 4'(~(1 << j)));
            chk("bit zero", 32'h1, {31'h0, skip_q});
            run(10'h000, 4'h0, 4'h0, 4'h0);
        end
        // clock enable low: the load must leave no trace
        @(posedge pclk);
        ce <= 1'b0;
        run(10'h231, 4'h7, 4'h7, 4'h0);
        chk("frozen strobe", 32'h0, {28'h0, tmr_load_q});
        chk("frozen value", 32'h0000_0096, {24'h0, tmr_load_val_q});
        @(posedge pclk);
        ce <= 1'b1;
        apb(1'b0, 12'h010, 32'h0);
        chk("frozen reload", 32'h0000_00b4, rdat);
        // reset in mid-run clears the sticky detector flag and the reload registers
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h008, 32'h0);
        chk("status after reset", 32'h0, rdat);
        apb(1'b0, 12'h01c, 32'h0);
        chk("reload after reset", 32'h0, rdat);
        end_of_test();
    end
endmodule
